// file: verilog/tmu_pkg.sv
package tmu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int TMU_NCH = 6;
  localparam int TMU_ADDR_W = 8;
  localparam int TMU_DATA_W = 16;
  localparam int TMU_CNT_W = 16;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TMU_OFS_IRQ_EN = 8'h00;
  localparam logic [7:0] TMU_OFS_STATUS = 8'h08;
  localparam logic [7:0] TMU_OFS_CH4_IOSEL = 8'h10;
  localparam logic [7:0] TMU_OFS_CH5_IOSEL = 8'h11;
  localparam logic [7:0] TMU_OFS_CH4_GRA = 8'h12;
  localparam logic [7:0] TMU_OFS_CH5_GRA = 8'h13;

  // ----------------------------------------------------------------
  // Enable and status bit positions
  // ----------------------------------------------------------------
  localparam int TMU_BIT_CONV = 7;
  localparam int TMU_BIT_RSVD1 = 6;
  localparam int TMU_BIT_UDF = 5;
  localparam int TMU_BIT_OVF = 4;
  localparam int TMU_BIT_D = 3;
  localparam int TMU_BIT_B = 1;
  localparam int TMU_BIT_A = 0;

  // Writable bits: channels 0 and 3 versus channels 1, 2, 4 and 5
  localparam logic [7:0] TMU_EN_MASK_D = 8'h9b;
  localparam logic [7:0] TMU_EN_MASK_U = 8'hb3;
  localparam logic [7:0] TMU_ST_MASK_D = 8'h1b;
  localparam logic [7:0] TMU_ST_MASK_U = 8'h33;
  localparam logic [7:0] TMU_RSVD_ONES = 8'h40;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMU_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] TMU_IOSEL_RST = 8'h00;
  localparam logic [15:0] TMU_GRA_RST = 16'hffff;
  localparam logic [15:0] TMU_CNT_MIN = 16'h0000;
  localparam logic [15:0] TMU_CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic udf;
    logic ovf;
    logic d;
    logic b;
    logic a;
  } tmu_irq_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } tmu_pin_t;

  typedef struct packed {
    logic [TMU_NCH-1:0][7:0] irq_en;
    logic [TMU_NCH-1:0][7:0] flag;
    logic [TMU_NCH-1:0][7:0] seen;
    logic [TMU_NCH-1:0][15:0] cnt_prev;
    logic [1:0][7:0] io_sel;
    logic [1:0][15:0] gra;
    logic [1:0] pin_lvl;
    logic [1:0] pin_prev;
    logic [TMU_NCH-1:0] conv;
    logic [15:0] rdata;
  } tmu_state_t;

endpackage : tmu_pkg

// file: verilog/tmu_io_irq.sv
module tmu_io_irq
  import tmu_pkg::*;
#(
  parameter int NCH = TMU_NCH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [TMU_ADDR_W-1:0] addr_i,
  input wire logic [TMU_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [TMU_DATA_W-1:0] rdata_o,
  input wire logic [NCH-1:0][TMU_CNT_W-1:0] counter_i,
  input wire logic [NCH-1:0] phase_mode_i,
  input wire logic [NCH-1:0] match_a_evt_i,
  input wire logic [NCH-1:0] match_b_evt_i,
  input wire logic [NCH-1:0] match_d_evt_i,
  input wire logic [NCH-1:0] overflow_evt_i,
  input wire logic ch3_a_event_i,
  input wire logic ch4_pin_a_i,
  output tmu_pin_t ch4_pin_a_o,
  input wire logic ch5_pin_a_i,
  output tmu_pin_t ch5_pin_a_o,
  output tmu_irq_t [NCH-1:0] irq_o,
  output logic [NCH-1:0] conv_start_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic has_d(input int ch);
    return (ch == 0) || (ch == 3);
  endfunction : has_d

  function automatic logic [7:0] en_mask(input int ch);
    return has_d(ch) ? TMU_EN_MASK_D : TMU_EN_MASK_U;
  endfunction : en_mask

  function automatic logic [7:0] st_mask(input int ch);
    return has_d(ch) ? TMU_ST_MASK_D : TMU_ST_MASK_U;
  endfunction : st_mask

  tmu_state_t s_r;
  tmu_state_t s_nxt;

  logic [1:0] pin_in;
  logic [1:0] cmp_mode;
  logic [1:0] cmp_match;
  logic [1:0] cap_evt;
  logic [1:0] a_evt_int;
  logic [NCH-1:0] a_evt;
  logic [NCH-1:0] udf_evt;

  assign pin_in = {ch5_pin_a_i, ch4_pin_a_i};

  // ----------------------------------------------------------------
  // Compare and capture for the A register of channels 4 and 5
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] sel;
    logic rise;
    logic fall;
    sel = 4'h0;
    rise = 1'b0;
    fall = 1'b0;
    for (int k = 0; k < 2; k++) begin
      sel = s_r.io_sel[k][3:0];
      rise = pin_in[k] & ~s_r.pin_prev[k];
      fall = ~pin_in[k] & s_r.pin_prev[k];
      cmp_mode[k] = ~sel[3];
      cmp_match[k] = cmp_mode[k] && (s_r.gra[k] == counter_i[4+k]);
      cap_evt[k] = 1'b0;
      if (sel[3]) begin
        if ((k == 0) && sel[2]) begin
          cap_evt[k] = ch3_a_event_i;
        end else if (sel[1]) begin
          cap_evt[k] = rise | fall;
        end else if (sel[0]) begin
          cap_evt[k] = fall;
        end else begin
          cap_evt[k] = rise;
        end
      end
      // Channel 5 reaches the pin branches whatever bit 2 holds
      a_evt_int[k] = cmp_match[k] | cap_evt[k];
    end
  end

  // ----------------------------------------------------------------
  // Per-channel event sources
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (c >= 4) begin
        a_evt[c] = a_evt_int[c-4];
      end else begin
        a_evt[c] = match_a_evt_i[c];
      end
      // Only phase counting channels can underflow
      udf_evt[c] = !has_d(c) && phase_mode_i[c] && (s_r.cnt_prev[c] == TMU_CNT_MIN)
                   && (counter_i[c] == TMU_CNT_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    set_v = 8'h00;
    clr_v = 8'h00;
    s_nxt = s_r;
    s_nxt.pin_prev = pin_in;
    s_nxt.rdata = '0;

    for (int c = 0; c < NCH; c++) begin
      s_nxt.cnt_prev[c] = counter_i[c];
      s_nxt.conv[c] = a_evt[c] & s_r.irq_en[c][TMU_BIT_CONV];
    end

    // Pin level on compare match
    for (int k = 0; k < 2; k++) begin
      if (cmp_match[k]) begin
        case (s_r.io_sel[k][1:0])
          2'b01: s_nxt.pin_lvl[k] = 1'b0;
          2'b10: s_nxt.pin_lvl[k] = 1'b1;
          2'b11: s_nxt.pin_lvl[k] = ~s_r.pin_lvl[k];
          default: s_nxt.pin_lvl[k] = s_r.pin_lvl[k];
        endcase
      end
      if (cap_evt[k]) begin
        s_nxt.gra[k] = counter_i[4+k];
      end
    end

    // Register reads; a read arms the clear of flags seen at one
    if (rd_i) begin
      if (addr_i >= TMU_OFS_IRQ_EN && addr_i < TMU_OFS_IRQ_EN + 8'(NCH)) begin
        s_nxt.rdata = {8'h00, s_r.irq_en[addr_i - TMU_OFS_IRQ_EN] | TMU_RSVD_ONES};
      end else if (addr_i >= TMU_OFS_STATUS && addr_i < TMU_OFS_STATUS + 8'(NCH)) begin
        s_nxt.rdata = {8'h00, s_r.flag[addr_i - TMU_OFS_STATUS] | TMU_RSVD_ONES};
        s_nxt.seen[addr_i - TMU_OFS_STATUS] = s_r.flag[addr_i - TMU_OFS_STATUS];
      end else if (addr_i == TMU_OFS_CH4_IOSEL) begin
        s_nxt.rdata = {8'h00, s_r.io_sel[0]};
      end else if (addr_i == TMU_OFS_CH5_IOSEL) begin
        s_nxt.rdata = {8'h00, s_r.io_sel[1]};
      end else if (addr_i == TMU_OFS_CH4_GRA) begin
        s_nxt.rdata = s_r.gra[0];
      end else if (addr_i == TMU_OFS_CH5_GRA) begin
        s_nxt.rdata = s_r.gra[1];
      end else begin
        s_nxt.rdata = '0;
      end
    end

    // Register writes
    if (wr_i) begin
      if (addr_i >= TMU_OFS_IRQ_EN && addr_i < TMU_OFS_IRQ_EN + 8'(NCH)) begin
        for (int c = 0; c < NCH; c++) begin
          if (addr_i == TMU_OFS_IRQ_EN + 8'(c)) begin
            s_nxt.irq_en[c] = wdata_i[7:0] & en_mask(c);
          end
        end
      end else if (addr_i == TMU_OFS_CH4_IOSEL || addr_i == TMU_OFS_CH5_IOSEL) begin
        for (int k = 0; k < 2; k++) begin
          if (addr_i == TMU_OFS_CH4_IOSEL + 8'(k)) begin
            s_nxt.io_sel[k] = wdata_i[7:0];
            // Initial level loads on the write, ahead of any match
            if (!wdata_i[3]) begin
              s_nxt.pin_lvl[k] = wdata_i[2];
            end
          end
        end
      end else if (addr_i == TMU_OFS_CH4_GRA) begin
        s_nxt.gra[0] = wdata_i;
      end else if (addr_i == TMU_OFS_CH5_GRA) begin
        s_nxt.gra[1] = wdata_i;
      end
    end

    // Flags: set wins over a clear in the same cycle
    for (int c = 0; c < NCH; c++) begin
      set_v = 8'h00;
      set_v[TMU_BIT_A] = a_evt[c];
      set_v[TMU_BIT_B] = match_b_evt_i[c];
      set_v[TMU_BIT_D] = match_d_evt_i[c];
      set_v[TMU_BIT_OVF] = overflow_evt_i[c];
      set_v[TMU_BIT_UDF] = udf_evt[c];
      set_v = set_v & st_mask(c);
      clr_v = 8'h00;
      if (wr_i && addr_i == TMU_OFS_STATUS + 8'(c)) begin
        clr_v = ~wdata_i[7:0] & s_r.seen[c];
        s_nxt.seen[c] = 8'h00;
      end
      s_nxt.flag[c] = ((s_r.flag[c] & ~clr_v) | set_v) & st_mask(c);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.irq_en <= {NCH{TMU_IRQ_EN_RST}};
      s_r.io_sel <= {2{TMU_IOSEL_RST}};
      s_r.gra <= {2{TMU_GRA_RST}};
      // Parked at the top: a counter resting at its maximum is no wrap
      s_r.cnt_prev <= {TMU_NCH{TMU_CNT_MAX}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = s_r.rdata;
  assign conv_start_o = s_r.conv;

  // Output is driven only in compare mode with a non-zero action code
  assign ch4_pin_a_o.level = s_r.pin_lvl[0];
  assign ch4_pin_a_o.oe_n = ~(~s_r.io_sel[0][3] && (s_r.io_sel[0][1:0] != 2'b00));
  assign ch5_pin_a_o.level = s_r.pin_lvl[1];
  assign ch5_pin_a_o.oe_n = ~(~s_r.io_sel[1][3] && (s_r.io_sel[1][1:0] != 2'b00));

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      irq_o[c].a = s_r.flag[c][TMU_BIT_A] & s_r.irq_en[c][TMU_BIT_A];
      irq_o[c].b = s_r.flag[c][TMU_BIT_B] & s_r.irq_en[c][TMU_BIT_B];
      irq_o[c].d = s_r.flag[c][TMU_BIT_D] & s_r.irq_en[c][TMU_BIT_D];
      irq_o[c].ovf = s_r.flag[c][TMU_BIT_OVF] & s_r.irq_en[c][TMU_BIT_OVF];
      irq_o[c].udf = s_r.flag[c][TMU_BIT_UDF] & s_r.irq_en[c][TMU_BIT_UDF];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_match_low;
    @(posedge clock_i) disable iff (rst_i)
      (cmp_match[0] && s_r.io_sel[0][1:0] == 2'b01 && !wr_i) |=> !ch4_pin_a_o.level;
  endproperty
  a_match_low: assert property (p_match_low)
    else $error("ch4 pin not low after match");

  property p_match_high;
    @(posedge clock_i) disable iff (rst_i)
      (cmp_match[1] && s_r.io_sel[1][1:0] == 2'b10 && !wr_i) |=> ch5_pin_a_o.level;
  endproperty
  a_match_high: assert property (p_match_high)
    else $error("ch5 pin not high after match");

  property p_match_toggle;
    @(posedge clock_i) disable iff (rst_i)
      (cmp_match[0] && s_r.io_sel[0][1:0] == 2'b11 && !wr_i)
        |=> (ch4_pin_a_o.level != $past(ch4_pin_a_o.level));
  endproperty
  a_match_toggle: assert property (p_match_toggle)
    else $error("ch4 pin did not toggle");

  property p_pin_disabled;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.io_sel[0][3] || s_r.io_sel[0][1:0] == 2'b00) |-> ch4_pin_a_o.oe_n;
  endproperty
  a_pin_disabled: assert property (p_pin_disabled)
    else $error("ch4 pin driven while off");

  property p_init_level;
    @(posedge clock_i) disable iff (rst_i)
      (wr_i && addr_i == TMU_OFS_CH4_IOSEL && !wdata_i[3])
        |=> (ch4_pin_a_o.level == $past(wdata_i[2]));
  endproperty
  a_init_level: assert property (p_init_level)
    else $error("initial level wrong");

  property p_cap_rise;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.io_sel[0][3:0] == 4'h8 && ch4_pin_a_i && !s_r.pin_prev[0] && !wr_i)
        |=> (s_r.gra[0] == $past(counter_i[4]));
  endproperty
  a_cap_rise: assert property (p_cap_rise)
    else $error("no capture on rising edge");

  property p_cap_fall_only;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.io_sel[0][3:0] == 4'h9 && ch4_pin_a_i && !s_r.pin_prev[0]) |-> !cap_evt[0];
  endproperty
  a_cap_fall_only: assert property (p_cap_fall_only)
    else $error("rising edge captured");

  property p_cap_both;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.io_sel[0][3:1] == 3'b101 && (ch4_pin_a_i != s_r.pin_prev[0])) |-> cap_evt[0];
  endproperty
  a_cap_both: assert property (p_cap_both)
    else $error("edge missed in both mode");

  property p_cap_ch3;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.io_sel[0][3:2] == 2'b11) |-> (cap_evt[0] == ch3_a_event_i);
  endproperty
  a_cap_ch3: assert property (p_cap_ch3)
    else $error("cascade capture wrong");

  property p_ch5_bit2;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.io_sel[1][3:0] == 4'hc && !ch5_pin_a_i && s_r.pin_prev[1]) |-> !cap_evt[1];
  endproperty
  a_ch5_bit2: assert property (p_ch5_bit2)
    else $error("ch5 bit 2 not ignored");

  property p_conv;
    @(posedge clock_i) disable iff (rst_i)
      conv_start_o[4] |-> ($past(a_evt[4]) && $past(s_r.irq_en[4][TMU_BIT_CONV]));
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter start without cause");

  property p_rsvd_one;
    @(posedge clock_i) disable iff (rst_i)
      (rd_i && addr_i < TMU_OFS_IRQ_EN + 8'(NCH)) |=> (rdata_o[6] && !rdata_o[2]);
  endproperty
  a_rsvd_one: assert property (p_rsvd_one)
    else $error("reserved enable bits wrong");

  property p_clear_armed;
    @(posedge clock_i) disable iff (rst_i)
      (s_r.flag[1][TMU_BIT_A] && !s_nxt.flag[1][TMU_BIT_A])
        |-> (wr_i && s_r.seen[1][TMU_BIT_A]);
  endproperty
  a_clear_armed: assert property (p_clear_armed)
    else $error("flag cleared unarmed");

  property p_irq_ovf;
    @(posedge clock_i) disable iff (rst_i)
      irq_o[1].ovf == (s_r.flag[1][TMU_BIT_OVF] && s_r.irq_en[1][TMU_BIT_OVF]);
  endproperty
  a_irq_ovf: assert property (p_irq_ovf)
    else $error("overflow irq wrong");

  property p_udf_set;
    @(posedge clock_i) disable iff (rst_i)
      (phase_mode_i[2] && s_r.cnt_prev[2] == TMU_CNT_MIN && counter_i[2] == TMU_CNT_MAX)
        |=> s_r.flag[2][TMU_BIT_UDF];
  endproperty
  a_udf_set: assert property (p_udf_set)
    else $error("underflow flag not set");

  property p_rsvd_zero;
    @(posedge clock_i) disable iff (rst_i)
      (rd_i && addr_i == TMU_OFS_IRQ_EN + 8'd3) |=> !rdata_o[5];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("underflow enable set on channel 3");

  property p_rsvd_d;
    @(posedge clock_i) disable iff (rst_i)
      (rd_i && addr_i == TMU_OFS_IRQ_EN + 8'd5) |=> !rdata_o[3];
  endproperty
  a_rsvd_d: assert property (p_rsvd_d)
    else $error("D enable set on channel 5");

endmodule : tmu_io_irq

// file: testbench/tmu_pin_model.sv
module tmu_pin_model
  import tmu_pkg::*;
(
  input wire tmu_pin_t ch4_drv_i,
  input wire tmu_pin_t ch5_drv_i,
  input wire logic [1:0] ext_lvl_i,
  output logic [1:0] line_o
);
  // ----------------------------------------------------------------
  // Shared pin lines
  // ----------------------------------------------------------------
  // The far-side source shows only while the block has let go of the pin
  assign line_o[0] = ch4_drv_i.oe_n ? ext_lvl_i[0] : ch4_drv_i.level;
  assign line_o[1] = ch5_drv_i.oe_n ? ext_lvl_i[1] : ch5_drv_i.level;
endmodule : tmu_pin_model

// file: testbench/tb_top.sv
module tb_top
  import tmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [5:0][15:0] counter_i = {6{16'h0100}};
  logic [5:0] phase_mode_i = 6'h00;
  logic [5:0] match_a_evt_i = 6'h00;
  logic [5:0] match_b_evt_i = 6'h00;
  logic [5:0] match_d_evt_i = 6'h00;
  logic [5:0] overflow_evt_i = 6'h00;
  logic ch3_a_event_i = 1'b0;
  logic [1:0] ext_lvl = 2'h0;
  logic [1:0] line;
  logic [15:0] rdata_o;
  tmu_pin_t ch4_pin_a_o;
  tmu_pin_t ch5_pin_a_o;
  tmu_irq_t [5:0] irq_o;
  logic [5:0] conv_start_o;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] cv [4] = '{16'h1111, 16'h0a0a, 16'h0b0b, 16'h0c0c};
  // Nibbles: channel, select code, initial level, level after match
  logic [15:0] cmp_rows [10] = '{16'h4000, 16'h4100, 16'h4201, 16'h4301, 16'h4411,
                                 16'h4510, 16'h4611, 16'h4710, 16'h5301, 16'h5611};
  // Nibbles: channel, code, index into cv after rise, ch3 event, fall
  logic [19:0] cap_rows [12] = '{20'h48111, 20'h49003, 20'h4a113, 20'h4b113, 20'h4c022,
                                 20'h4f022, 20'h58111, 20'h5c111, 20'h59003, 20'h5d003,
                                 20'h5a113, 20'h5f113};

  always #5 clock_i = ~clock_i;

  tmu_io_irq uut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .counter_i,
    .phase_mode_i, .match_a_evt_i, .match_b_evt_i, .match_d_evt_i, .overflow_evt_i,
    .ch3_a_event_i, .ch4_pin_a_i(line[0]), .ch4_pin_a_o, .ch5_pin_a_i(line[1]),
    .ch5_pin_a_o, .irq_o, .conv_start_o);

  tmu_pin_model pins (.ch4_drv_i(ch4_pin_a_o), .ch5_drv_i(ch5_pin_a_o),
    .ext_lvl_i(ext_lvl), .line_o(line));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rchk

  // Bit 0 A match, 1 B match, 2 D match, 3 overflow
  task ev(input logic [3:0] w, input int ch);
    @(posedge clock_i);
    match_a_evt_i[ch] <= w[0];
    match_b_evt_i[ch] <= w[1];
    match_d_evt_i[ch] <= w[2];
    overflow_evt_i[ch] <= w[3];
    @(posedge clock_i);
    match_a_evt_i <= 6'h00;
    match_b_evt_i <= 6'h00;
    match_d_evt_i <= 6'h00;
    overflow_evt_i <= 6'h00;
    #1;
  endtask : ev

  function automatic logic [15:0] pin(input int ch);
    tmu_pin_t p;
    p = (ch == 4) ? ch4_pin_a_o : ch5_pin_a_o;
    return {14'h0000, p.oe_n, p.level};
  endfunction : pin

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int ch;
    logic [3:0] code;
    logic [15:0] exp_v;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(TMU_OFS_CH4_IOSEL, 16'h0000);
    chk(pin(4), 16'h0002);
    for (int i = 0; i < 6; i++) begin
      rchk(TMU_OFS_IRQ_EN + 8'(i), 16'h0040);
    end
    for (int i = 0; i < 6; i++) begin
      wr(TMU_OFS_IRQ_EN + 8'(i), (i % 2 == 1) ? 16'h00ff : 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      rchk(8'(i), {8'h00, TMU_RSVD_ONES | ((i % 2 == 0) ? 8'h00 :
        ((i == 3) ? TMU_EN_MASK_D : TMU_EN_MASK_U))});
    end
    // Unmapped place must swallow writes and read as zero
    wr(8'h20, 16'hffff);
    rchk(8'h20, 16'h0000);
    wr(TMU_OFS_IRQ_EN + 8'd4, 16'h0080);
    wr(TMU_OFS_IRQ_EN + 8'd5, 16'h0000);
    wr(TMU_OFS_CH4_GRA, 16'h0005);
    wr(TMU_OFS_CH5_GRA, 16'h0005);
    foreach (cmp_rows[j]) begin
      ch = int'(cmp_rows[j][15:12]);
      code = cmp_rows[j][11:8];
      wr(TMU_OFS_CH4_IOSEL + 8'(ch - 4), {12'h000, code});
      chk(pin(ch), {14'h0000, code[1:0] == 2'b00, cmp_rows[j][4]});
      @(posedge clock_i);
      counter_i[ch] <= 16'h0005;
      @(posedge clock_i);
      counter_i[ch] <= 16'h0100;
      #1;
      chk(pin(ch), {14'h0000, code[1:0] == 2'b00, cmp_rows[j][0]});
      chk({15'h0000, conv_start_o[ch]}, {15'h0000, ch == 4});
    end
    foreach (cap_rows[j]) begin
      ch = int'(cap_rows[j][19:16]);
      wr(TMU_OFS_CH4_IOSEL + 8'(ch - 4), {12'h000, cap_rows[j][15:12]});
      wr(TMU_OFS_CH4_GRA + 8'(ch - 4), cv[0]);
      for (int k = 1; k < 4; k++) begin
        @(posedge clock_i);
        counter_i[ch] <= cv[k];
        if (k == 2) begin
          ch3_a_event_i <= 1'b1;
        end else begin
          ext_lvl[ch - 4] <= (k == 1);
        end
        @(posedge clock_i);
        ch3_a_event_i <= 1'b0;
        exp_v = cv[cap_rows[j][12 - 4 * k +: 2]];
        rchk(TMU_OFS_CH4_GRA + 8'(ch - 4), exp_v);
      end
    end
    // Flag set while masked, then a clear attempt with no read first
    wr(TMU_OFS_IRQ_EN + 8'd1, 16'h0000);
    ev(4'b1000, 1);
    chk({11'h000, irq_o[1]}, 16'h0000);
    wr(TMU_OFS_STATUS + 8'd1, 16'h0000);
    wr(TMU_OFS_IRQ_EN + 8'd1, 16'h0013);
    chk({11'h000, irq_o[1]}, 16'h0008);
    ev(4'b0011, 1);
    chk({11'h000, irq_o[1]}, 16'h000b);
    rchk(TMU_OFS_STATUS + 8'd1, 16'h0053);
    wr(TMU_OFS_STATUS + 8'd1, 16'h0010);
    chk({11'h000, irq_o[1]}, 16'h0008);
    wr(TMU_OFS_IRQ_EN + 8'd2, 16'h0020);
    wr(TMU_OFS_IRQ_EN, 16'h0008);
    @(posedge clock_i);
    phase_mode_i <= 6'h04;
    counter_i[2] <= 16'h0000;
    @(posedge clock_i);
    counter_i[2] <= 16'hffff;
    ev(4'b0100, 0);
    chk({11'h000, irq_o[2]}, 16'h0010);
    chk({11'h000, irq_o[0]}, 16'h0004);
    // Enable dropped while the underflow flag stands
    wr(TMU_OFS_IRQ_EN + 8'd2, 16'h0000);
    chk({11'h000, irq_o[2]}, 16'h0000);
    // Reset in mid-run, with a counter parked at its maximum
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(TMU_OFS_CH5_IOSEL, 16'h0000);
    rchk(TMU_OFS_STATUS + 8'd2, 16'h0040);
    rchk(TMU_OFS_IRQ_EN + 8'd1, 16'h0040);
    stop_test();
  end
endmodule : tb_top
